// file: src/dagu_core.sv
// Purpose: data address generation unit: pointers, base, stack and bank exchange
// Assumes: decoder keeps long indexed words back to back and obeys busy
// Notes:   addresses are registered; they appear one cycle after the command
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////////////////////
module dagu_core (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // decoder commands
   input  wire dagu_pkg::dagu_cmd_s    cmd,
   input  wire logic [15:0]           pc_value,
   input  wire logic [5:0]            wrap_enable_bits,
   output      logic                  busy,
   // register access over the x data bus
   input  wire dagu_pkg::dagu_regbus_s x_data_bus,
   output      logic [15:0]           x_data_rd,
   // memory side
   output      dagu_pkg::dagu_addr_s   addr_out
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // helpers

   // spreads the limit downward so its ones cover the k low bits
   function automatic logic [15:0] wrap_mask(input logic [15:0] cfg);
      logic [8:0] m;
      m = cfg[dagu_pkg::WRAP_LSB +: dagu_pkg::WRAP_W];
      // zero limit: empty mask, pointer holds
      m = m | (m >> 1);
      m = m | (m >> 2);
      m = m | (m >> 4);
      m = m | (m >> 8);
      return {7'h00, m};
   endfunction

   function automatic logic [15:0] step_of(input dagu_pkg::dagu_mod_e md,
                                           input logic [15:0] cfg);
      logic [6:0] s;
      s = cfg[dagu_pkg::STEP_LSB +: dagu_pkg::STEP_W];
      case (md)
         dagu_pkg::DAGU_MOD_INC:  return 16'h0001;
         dagu_pkg::DAGU_MOD_DEC:  return 16'hFFFF;
         dagu_pkg::DAGU_MOD_STEP: return {{9{s[6]}}, s};
         // no modification adds zero
         default:                 return 16'h0000;
      endcase
   endfunction

   function automatic logic [15:0] post_mod(input logic [15:0] p,
                                            input logic [15:0] q,
                                            input logic [15:0] cfg,
                                            input logic        wrap);
      logic [15:0] msk;
      logic [15:0] lim;
      logic [15:0] low;
      logic [15:0] sum;
      msk = wrap_mask(cfg);
      lim = {7'h00, cfg[dagu_pkg::WRAP_LSB +: dagu_pkg::WRAP_W]};
      low = p & msk;
      // plain 16-bit sum wraps modulo 65536
      sum = p + q;
      if (!wrap) begin
         return sum;
      end
      // nine-bit limit gives up to nine modulo bits, moduli up to 512
      // step sign, not sum sign, picks direction
      if (!q[15]) begin
         if (low == lim) begin
            return p & ~msk;
         end
         return (p & ~msk) | (sum & msk);
      end
      if (low == 16'h0000) begin
         return (p & ~msk) | lim;
      end
      return (p & ~msk) | (sum & msk);
   endfunction

   function automatic logic [15:0] sext_short(input logic [15:0] imm);
      return {{9{imm[6]}}, imm[6:0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // state
   dagu_pkg::dagu_state_s state_reg;
   dagu_pkg::dagu_state_s state_next;

   logic [2:0]  i_idx;
   logic [2:0]  j_idx;
   logic [15:0] i_cfg;
   logic [15:0] i_q;
   logic [15:0] j_q;
   logic [15:0] rd_mux;
   logic [15:0] tmp;
   logic        i_ok;
   logic        i_wrap;
   logic        j_wrap;
   logic [15:0] short_addr;
   logic [15:0] long_addr;

   // group j pointers pick the group j word
   assign i_idx = cmd.i_sel;
   assign j_idx = cmd.j_sel ? 3'h5 : 3'h4;
   assign i_cfg = (cmd.i_sel >= dagu_pkg::FIRST_J_PTR) ? state_reg.cfgj : state_reg.cfgi;
   assign i_q   = step_of(cmd.i_mod, i_cfg);
   assign j_q   = step_of(cmd.j_mod, state_reg.cfgj);
   // codes six and seven name no pointer; dropped
   assign i_ok       = (cmd.i_sel < 3'h6);
   assign i_wrap     = wrap_enable_bits[i_idx] & ~cmd.i_modr;
   assign j_wrap     = wrap_enable_bits[j_idx] & ~cmd.j_modr;
   assign short_addr = state_reg.base + sext_short(cmd.idx_imm);
   assign long_addr  = state_reg.base + cmd.idx_imm;

   // read mux over every addressable register
   always_comb begin
      case (x_data_bus.sel)
         dagu_pkg::DAGU_REG_PTR0:   rd_mux = state_reg.ptr[0];
         dagu_pkg::DAGU_REG_PTR1:   rd_mux = state_reg.ptr[1];
         dagu_pkg::DAGU_REG_PTR2:   rd_mux = state_reg.ptr[2];
         dagu_pkg::DAGU_REG_PTR3:   rd_mux = state_reg.ptr[3];
         dagu_pkg::DAGU_REG_PTR4:   rd_mux = state_reg.ptr[4];
         dagu_pkg::DAGU_REG_PTR5:   rd_mux = state_reg.ptr[5];
         dagu_pkg::DAGU_REG_BASE:   rd_mux = state_reg.base;
         dagu_pkg::DAGU_REG_STACK:  rd_mux = state_reg.sp;
         dagu_pkg::DAGU_REG_CFG_I:  rd_mux = state_reg.cfgi;
         dagu_pkg::DAGU_REG_CFG_J:  rd_mux = state_reg.cfgj;
         dagu_pkg::DAGU_REG_MINMAX: rd_mux = state_reg.minmax;
         // spare codes read zero
         default:                   rd_mux = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next            = state_reg;
      tmp                   = 16'h0000;
      state_next.out.x_vld  = 1'b0;
      state_next.out.y_vld  = 1'b0;
      state_next.out.mem_wr = 1'b0;
      state_next.out.mem_rd = 1'b0;

      case (state_reg.fsm)
         dagu_pkg::DAGU_LONG: begin
            // second word is the 16-bit offset
            // base is read, never written back
            state_next.out.x_vld  = 1'b1;
            state_next.out.x_addr = long_addr;
            // other command fields wait for idle
            state_next.fsm        = dagu_pkg::DAGU_IDLE;
         end
         dagu_pkg::DAGU_IDLE: begin
            // group i address drives x, group j drives y
            if (cmd.i_en && i_ok) begin
               state_next.out.x_vld  = 1'b1;
               state_next.out.x_addr = state_reg.ptr[i_idx];
               state_next.ptr[i_idx] = post_mod(state_reg.ptr[i_idx], i_q, i_cfg,
                                                i_wrap);
            end
            if (cmd.j_en) begin
               state_next.out.y_vld  = 1'b1;
               state_next.out.y_addr = state_reg.ptr[j_idx];
               // group j limit field
               // j after i: shared pointer keeps j
               state_next.ptr[j_idx] = post_mod(state_reg.ptr[j_idx], j_q, state_reg.cfgj,
                                                j_wrap);
            end

            case (cmd.idx)
               dagu_pkg::DAGU_IDX_SHORT: begin
                  state_next.out.x_vld  = 1'b1;
                  state_next.out.x_addr = short_addr;
               end
               dagu_pkg::DAGU_IDX_LONG: begin
                  state_next.fsm = dagu_pkg::DAGU_LONG;
               end
               default: begin
               end
            endcase

            case (cmd.stk)
               dagu_pkg::DAGU_STK_PUSH, dagu_pkg::DAGU_STK_CALL: begin
                  // address and data leave together
                  // pre-decrement then write
                  tmp                      = state_reg.sp - 16'h0001;
                  state_next.sp            = tmp;
                  state_next.out.x_vld     = 1'b1;
                  state_next.out.x_addr    = tmp;
                  state_next.out.mem_wr    = 1'b1;
                  state_next.out.mem_wdata = (cmd.stk == dagu_pkg::DAGU_STK_CALL) ?
                                             pc_value : cmd.push_data;
               end
               dagu_pkg::DAGU_STK_POP, dagu_pkg::DAGU_STK_RET: begin
                  state_next.sp         = state_reg.sp + 16'h0001;
                  state_next.out.x_vld  = 1'b1;
                  state_next.out.x_addr = state_reg.sp;
                  state_next.out.mem_rd = 1'b1;
               end
               dagu_pkg::DAGU_STK_RETD: begin
                  // pop plus signed drop of passed words
                  state_next.sp         = state_reg.sp + 16'h0001 +
                                          {{8{cmd.stk_imm[7]}}, cmd.stk_imm};
                  state_next.out.x_vld  = 1'b1;
                  state_next.out.x_addr = state_reg.sp;
                  state_next.out.mem_rd = 1'b1;
               end
               dagu_pkg::DAGU_STK_PEEK: begin
                  state_next.out.x_vld  = 1'b1;
                  state_next.out.x_addr = state_reg.sp;
                  state_next.out.mem_rd = 1'b1;
               end
               default: begin
               end
            endcase

            // swap after the i and j updates, so it wins on a shared pointer
            // swap each selected register with its alternate
            if (cmd.bank_mask[dagu_pkg::BANK_PTR0]) begin
               state_next.ptr[0]     = state_reg.alt_ptr[0];
               state_next.alt_ptr[0] = state_reg.ptr[0];
            end
            if (cmd.bank_mask[dagu_pkg::BANK_PTR1]) begin
               state_next.ptr[1]     = state_reg.alt_ptr[1];
               state_next.alt_ptr[1] = state_reg.ptr[1];
            end
            if (cmd.bank_mask[dagu_pkg::BANK_PTR4]) begin
               state_next.ptr[4]     = state_reg.alt_ptr[2];
               state_next.alt_ptr[2] = state_reg.ptr[4];
            end
            if (cmd.bank_mask[dagu_pkg::BANK_CFGI]) begin
               state_next.cfgi     = state_reg.alt_cfgi;
               state_next.alt_cfgi = state_reg.cfgi;
            end
         end
         default: begin
            state_next.fsm = dagu_pkg::DAGU_IDLE;
         end
      endcase

      if (x_data_bus.rd_en) begin
         state_next.rd_data = rd_mux;
      end

      // bus writes come last so software wins over a same-cycle update
      // register write from the data bus
      if (x_data_bus.wr_en) begin
         case (x_data_bus.sel)
            dagu_pkg::DAGU_REG_PTR0:   state_next.ptr[0] = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_PTR1:   state_next.ptr[1] = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_PTR2:   state_next.ptr[2] = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_PTR3:   state_next.ptr[3] = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_PTR4:   state_next.ptr[4] = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_PTR5:   state_next.ptr[5] = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_BASE:   state_next.base   = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_STACK:  state_next.sp     = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_CFG_I:  state_next.cfgi   = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_CFG_J:  state_next.cfgj   = x_data_bus.wdata;
            dagu_pkg::DAGU_REG_MINMAX: state_next.minmax = x_data_bus.wdata;
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // registers
   // the whole register set lives in one state word
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg.ptr       <= {dagu_pkg::NUM_PTR{dagu_pkg::PTR_RST}};
         state_reg.alt_ptr   <= {dagu_pkg::NUM_ALT{dagu_pkg::PTR_RST}};
         state_reg.alt_cfgi  <= dagu_pkg::CFG_RST;
         state_reg.cfgi      <= dagu_pkg::CFG_RST;
         state_reg.cfgj      <= dagu_pkg::CFG_RST;
         state_reg.base      <= dagu_pkg::BASE_RST;
         state_reg.sp        <= dagu_pkg::SP_RST;
         state_reg.minmax    <= dagu_pkg::PTR_RST;
         state_reg.rd_data   <= 16'h0000;
         state_reg.out.x_vld     <= 1'b0;
         state_reg.out.x_addr    <= 16'h0000;
         state_reg.out.y_vld     <= 1'b0;
         state_reg.out.y_addr    <= 16'h0000;
         state_reg.out.mem_wr    <= 1'b0;
         state_reg.out.mem_rd    <= 1'b0;
         state_reg.out.mem_wdata <= 16'h0000;
         state_reg.fsm       <= dagu_pkg::DAGU_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // outputs
   // busy only covers the second word of a long index; decoder must hold new work
   assign busy      = (state_reg.fsm == dagu_pkg::DAGU_LONG);
   assign x_data_rd = state_reg.rd_data;
   assign addr_out  = state_reg.out;

endmodule

// file: src/dagu_pkg.sv
// Purpose: shared constants and types of the data address generation unit
// Assumes: 16-bit data and address words
// Notes:   field positions of the configuration words live here
package dagu_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // widths and field positions
   localparam int DATA_W   = 16;
   localparam int NUM_PTR  = 6;
   localparam int NUM_ALT  = 3;
   localparam int STEP_LSB = 0;
   localparam int STEP_W   = 7;
   localparam int WRAP_LSB = 7;
   localparam int WRAP_W   = 9;
   localparam int SIMM_W   = 7;
   localparam int RIMM_W   = 8;

   // pointers four and five form group j
   localparam logic [2:0] FIRST_J_PTR = 3'h4;

   // bank exchange select bits
   localparam int BANK_PTR0 = 0;
   localparam int BANK_PTR1 = 1;
   localparam int BANK_PTR4 = 2;
   localparam int BANK_CFGI = 3;

   // values after reset
   localparam logic [15:0] PTR_RST  = 16'h0000;
   localparam logic [15:0] CFG_RST  = 16'h0000;
   localparam logic [15:0] BASE_RST = 16'h0000;
   localparam logic [15:0] SP_RST   = 16'h0000;

   // long indexed access spans this many cycles
   localparam int LONG_IDX_CYCLES = 2;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // enumerations
   typedef enum logic [1:0] {DAGU_MOD_NONE, DAGU_MOD_INC, DAGU_MOD_DEC,
                             DAGU_MOD_STEP} dagu_mod_e;
   typedef enum logic [1:0] {DAGU_IDX_NONE, DAGU_IDX_SHORT, DAGU_IDX_LONG} dagu_idx_e;
   typedef enum logic [2:0] {DAGU_STK_NONE, DAGU_STK_PUSH, DAGU_STK_POP, DAGU_STK_PEEK,
                             DAGU_STK_CALL, DAGU_STK_RET, DAGU_STK_RETD} dagu_stk_e;
   typedef enum logic [3:0] {DAGU_REG_PTR0, DAGU_REG_PTR1, DAGU_REG_PTR2, DAGU_REG_PTR3,
                             DAGU_REG_PTR4, DAGU_REG_PTR5, DAGU_REG_BASE, DAGU_REG_STACK,
                             DAGU_REG_CFG_I, DAGU_REG_CFG_J, DAGU_REG_MINMAX} dagu_reg_e;
   typedef enum logic {DAGU_IDLE, DAGU_LONG} dagu_fsm_e;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic        i_en;
      logic [2:0]  i_sel;
      dagu_mod_e   i_mod;
      logic        i_modr;
      logic        j_en;
      logic        j_sel;
      dagu_mod_e   j_mod;
      logic        j_modr;
      dagu_idx_e   idx;
      logic [15:0] idx_imm;
      dagu_stk_e   stk;
      logic [7:0]  stk_imm;
      logic [15:0] push_data;
      logic [3:0]  bank_mask;
   } dagu_cmd_s;

   typedef struct packed {
      logic        wr_en;
      logic        rd_en;
      dagu_reg_e   sel;
      logic [15:0] wdata;
   } dagu_regbus_s;

   typedef struct packed {
      logic        x_vld;
      logic [15:0] x_addr;
      logic        y_vld;
      logic [15:0] y_addr;
      logic        mem_wr;
      logic        mem_rd;
      logic [15:0] mem_wdata;
   } dagu_addr_s;

   typedef struct packed {
      logic [5:0][15:0] ptr;
      logic [2:0][15:0] alt_ptr;
      logic [15:0]      alt_cfgi;
      logic [15:0]      cfgi;
      logic [15:0]      cfgj;
      logic [15:0]      base;
      logic [15:0]      sp;
      logic [15:0]      minmax;
      logic [15:0]      rd_data;
      dagu_addr_s       out;
      dagu_fsm_e        fsm;
   } dagu_state_s;

endpackage

// file: verification/dagu_core_checker.sv
// Purpose: port assertions for dagu_core
// Assumes: the base register changes only by bus writes
// Notes:   bound to the core after the module
`timescale 1ns/100ps
module dagu_checker (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst,
   // decoder side
   input wire dagu_pkg::dagu_cmd_s    cmd,
   input wire logic [15:0]           pc_value,
   input wire logic [5:0]            wrap_enable_bits,
   input wire logic                  busy,
   // bus and memory side
   input wire dagu_pkg::dagu_regbus_s x_data_bus,
   input wire logic [15:0]           x_data_rd,
   input wire dagu_pkg::dagu_addr_s   addr_out
);
   logic        free;
   logic        i_only;
   logic [15:0] base_reg;
   logic [15:0] short_sum;
   logic [15:0] long_sum;
   assign free = !busy && cmd.stk == dagu_pkg::DAGU_STK_NONE;
   // j channel and bus writes excluded: either may retarget the same pointer
   assign i_only = free && cmd.idx == dagu_pkg::DAGU_IDX_NONE && cmd.i_en && !cmd.j_en
                   && !x_data_bus.wr_en;
   assign short_sum = base_reg + {{9{cmd.idx_imm[6]}}, cmd.idx_imm[6:0]};
   assign long_sum = base_reg + cmd.idx_imm;
   always_ff @(posedge clk) begin
      if (rst) begin
         base_reg <= dagu_pkg::BASE_RST;
      end else if (x_data_bus.wr_en && x_data_bus.sel == dagu_pkg::DAGU_REG_BASE) begin
         base_reg <= x_data_bus.wdata;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   property p_long_busy;
      free && cmd.idx == dagu_pkg::DAGU_IDX_LONG |=> busy ##1 !busy;
   endproperty
   a_long_busy: assert property (p_long_busy) else $error("busy not one cycle");
   property p_long_addr;
      free && cmd.idx == dagu_pkg::DAGU_IDX_LONG ##1 busy
         |=> addr_out.x_vld && addr_out.x_addr == $past(long_sum);
   endproperty
   a_long_addr: assert property (p_long_addr) else $error("long index address");
   property p_short_addr;
      free && cmd.idx == dagu_pkg::DAGU_IDX_SHORT
         |=> addr_out.x_vld && addr_out.x_addr == $past(short_sum);
   endproperty
   a_short_addr: assert property (p_short_addr) else $error("short index address");
   property p_push;
      !busy && cmd.stk == dagu_pkg::DAGU_STK_PUSH
         |=> addr_out.mem_wr && addr_out.mem_wdata == $past(cmd.push_data);
   endproperty
   a_push: assert property (p_push) else $error("push write wrong");
   property p_call;
      !busy && cmd.stk == dagu_pkg::DAGU_STK_CALL
         |=> addr_out.mem_wr && addr_out.mem_wdata == $past(pc_value);
   endproperty
   a_call: assert property (p_call) else $error("call does not store pc");
   property p_push_peek;
      !busy && cmd.stk == dagu_pkg::DAGU_STK_PUSH ##1 cmd.stk == dagu_pkg::DAGU_STK_PEEK
         |=> addr_out.mem_rd && addr_out.x_addr == $past(addr_out.x_addr);
   endproperty
   a_push_peek: assert property (p_push_peek) else $error("peek not at top");
   property p_modr_inc;
      i_only && cmd.i_modr && cmd.i_mod == dagu_pkg::DAGU_MOD_INC
         ##1 i_only && cmd.i_sel == $past(cmd.i_sel)
         |=> addr_out.x_addr == $past(addr_out.x_addr) + 16'h0001;
   endproperty
   a_modr_inc: assert property (p_modr_inc) else $error("modify not linear");
   property p_reg_back;
      x_data_bus.wr_en && x_data_bus.sel == dagu_pkg::DAGU_REG_CFG_J
         ##1 x_data_bus.rd_en && x_data_bus.sel == dagu_pkg::DAGU_REG_CFG_J
         |=> x_data_rd == $past(x_data_bus.wdata, 2);
   endproperty
   a_reg_back: assert property (p_reg_back) else $error("register readback");
   c_long: cover property (free && cmd.idx == dagu_pkg::DAGU_IDX_LONG);
   c_bank: cover property (!busy && cmd.bank_mask == 4'hF);
   c_retd: cover property (!busy && cmd.stk == dagu_pkg::DAGU_STK_RETD);
endmodule

bind dagu_core dagu_checker u_chk (.clk(clk), .rst(rst), .cmd(cmd), .pc_value(pc_value),
   .wrap_enable_bits(wrap_enable_bits), .busy(busy), .x_data_bus(x_data_bus),
   .x_data_rd(x_data_rd), .addr_out(addr_out));

// file: verification/dagu_core_test.sv
// Purpose: self-checking bench for dagu_core
// Assumes: inputs change and outputs are read at the falling edge
// Notes:   random data from a 16-bit lfsr seeded with 25536
`timescale 1ns/100ps
module dagu_core_test;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   dagu_pkg::dagu_cmd_s    cmd = '0;
   logic [15:0]           pc_value = 16'h0000;
   logic [5:0]            wrap_enable_bits = 6'h00;
   dagu_pkg::dagu_regbus_s x_data_bus = '0;
   logic                  busy;
   logic [15:0]           x_data_rd;
   dagu_pkg::dagu_addr_s   addr_out;
   logic [15:0]           rd_word;
   int                    errors = 0;
   int                    checks_done = 0;
   int                    cycles = 0;
   logic [15:0]           seed = 16'h63C0;
   logic [15:0]           cur [4] = '{4{16'h0000}};
   logic [15:0]           alt [4] = '{4{16'h0000}};
   // limits are modulus minus step, starts aligned
   logic [8:0]            lim_t [4] = '{9'h006, 9'h006, 9'h005, 9'h1F8};
   logic [6:0]            step_t [4] = '{7'h01, 7'h7D, 7'h03, 7'h3F};
   logic [15:0]           start_t [4] = '{16'h0010, 16'h0016, 16'h0010, 16'h0400};
   logic [15:0]           modr_t [4] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFBF};
   dagu_pkg::dagu_reg_e    bank_t [4] = '{dagu_pkg::DAGU_REG_PTR0, dagu_pkg::DAGU_REG_PTR1,
                                         dagu_pkg::DAGU_REG_PTR4, dagu_pkg::DAGU_REG_CFG_I};

   always #10 clk = ~clk;

   dagu_core DUT (.clk(clk), .rst(rst), .cmd(cmd), .pc_value(pc_value),
      .wrap_enable_bits(wrap_enable_bits), .busy(busy), .x_data_bus(x_data_bus),
      .x_data_rd(x_data_rd), .addr_out(addr_out));
   dagu_mem_model u_mem (.clk(clk), .addr_out(addr_out), .rd_word(rd_word));

   ////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   function automatic logic [15:0] mod_next(logic [15:0] r, logic [6:0] q, logic [8:0] l);
      logic [15:0] m;
      logic [15:0] s;
      m = {7'h00, l | l >> 1 | l >> 2 | l >> 3 | l >> 4 | l >> 5 | l >> 6 | l >> 7 | l >> 8};
      s = r + {{9{q[6]}}, q};
      if (!q[6] && (r & m) == {7'h00, l}) s = 16'h0000;
      if (q[6] && (r & m) == 16'h0000) s = {7'h00, l};
      return (r & ~m) | (s & m);
   endfunction
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask
   task automatic op(dagu_pkg::dagu_cmd_s c, dagu_pkg::dagu_regbus_s b);
      cmd = c;
      x_data_bus = b;
      @(negedge clk);
   endtask
   task automatic wr(dagu_pkg::dagu_reg_e s, logic [15:0] d);
      op('0, '{1'b1, 1'b0, s, d});
   endtask
   task automatic rd(dagu_pkg::dagu_reg_e s, logic [15:0] e);
      op('0, '{1'b0, 1'b1, s, 16'h0000});
      chk("read data", e, x_data_rd);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // limit far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         finish_test();
      end
   end

   ////////////////////////////////////////
   initial begin
      dagu_pkg::dagu_cmd_s c;
      logic [15:0] b;
      logic [15:0] d;
      logic [15:0] e1;
      logic [15:0] e2;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      for (int i = 0; i <= 10; i++) rd(dagu_pkg::dagu_reg_e'(i), 16'h0000);
      rd(dagu_pkg::dagu_reg_e'(4'hF), 16'h0000);
      for (int i = 0; i <= 10; i++) begin
         d = rnd();
         wr(dagu_pkg::dagu_reg_e'(i), d);
         rd(dagu_pkg::dagu_reg_e'(i), d);
      end
      $display("register test done");
      wrap_enable_bits = 6'h3F;
      for (int t = 0; t < 4; t++) begin
         e1 = start_t[t];
         e2 = start_t[(t + 1) % 4];
         wr(dagu_pkg::DAGU_REG_PTR1, e1);
         wr(dagu_pkg::DAGU_REG_PTR5, e2);
         wr(dagu_pkg::DAGU_REG_CFG_I, {lim_t[t], step_t[t]});
         wr(dagu_pkg::DAGU_REG_CFG_J, {lim_t[(t + 1) % 4], step_t[(t + 1) % 4]});
         c = '0;
         c.i_en = 1'b1;
         c.i_sel = 3'h1;
         c.i_mod = dagu_pkg::DAGU_MOD_STEP;
         c.j_en = 1'b1;
         c.j_sel = 1'b1;
         c.j_mod = dagu_pkg::DAGU_MOD_STEP;
         repeat (10) begin
            op(c, '0);
            chk("x address", e1, addr_out.x_addr);
            chk("y address", e2, addr_out.y_addr);
            chk("y valid", 16'h0001, {15'h0000, addr_out.y_vld});
            e1 = mod_next(e1, step_t[t], lim_t[t]);
            e2 = mod_next(e2, step_t[(t + 1) % 4], lim_t[(t + 1) % 4]);
         end
      end
      $display("modulo test done");
      wr(dagu_pkg::DAGU_REG_CFG_I, 16'h0340);
      wr(dagu_pkg::DAGU_REG_PTR2, 16'hFFFF);
      c = '0;
      c.i_en = 1'b1;
      c.i_sel = 3'h2;
      c.i_modr = 1'b1;
      for (int i = 0; i < 4; i++) begin
         c.i_mod = dagu_pkg::dagu_mod_e'((i + 1) % 4);
         op(c, '0);
         chk("modify address", modr_t[i], addr_out.x_addr);
      end
      wrap_enable_bits = 6'h3B;
      c.i_modr = 1'b0;
      c.i_mod = dagu_pkg::DAGU_MOD_INC;
      repeat (2) op(c, '0);
      chk("unwrapped address", 16'hFFC0, addr_out.x_addr);
      $display("linear test done");
      b = rnd();
      d = rnd();
      wr(dagu_pkg::DAGU_REG_BASE, b);
      c = '0;
      c.idx = dagu_pkg::DAGU_IDX_SHORT;
      c.idx_imm = 16'h0040;
      op(c, '0);
      chk("short index", b - 16'h0040, addr_out.x_addr);
      c.idx_imm = 16'hFFBF;
      op(c, '0);
      chk("short index", b + 16'h003F, addr_out.x_addr);
      c.idx = dagu_pkg::DAGU_IDX_LONG;
      op(c, '0);
      chk("busy", 16'h0001, {15'h0000, busy});
      c = '0;
      c.idx_imm = d;
      op(c, '0);
      chk("long index", b + d, addr_out.x_addr);
      rd(dagu_pkg::DAGU_REG_BASE, b);
      $display("index test done");
      wr(dagu_pkg::DAGU_REG_STACK, 16'h0100);
      d = rnd();
      b = rnd();
      c = '0;
      c.stk = dagu_pkg::DAGU_STK_PUSH;
      c.push_data = d;
      op(c, '0);
      chk("push address", 16'h00FF, addr_out.x_addr);
      c.push_data = b;
      op(c, '0);
      c.stk = dagu_pkg::DAGU_STK_PEEK;
      op(c, '0);
      chk("peek address", 16'h00FE, addr_out.x_addr);
      c.stk = dagu_pkg::DAGU_STK_POP;
      op(c, '0);
      chk("pop address", 16'h00FE, addr_out.x_addr);
      pc_value = rnd();
      c.stk = dagu_pkg::DAGU_STK_CALL;
      op(c, '0);
      chk("call address", 16'h00FE, addr_out.x_addr);
      chk("pop data", b, rd_word);
      c.stk = dagu_pkg::DAGU_STK_RET;
      op(c, '0);
      c.stk = dagu_pkg::DAGU_STK_RETD;
      c.stk_imm = 8'hFF;
      op(c, '0);
      chk("return word", pc_value, rd_word);
      rd(dagu_pkg::DAGU_REG_STACK, 16'h00FF);
      chk("dropped word", d, rd_word);
      $display("stack test done");
      for (int m = 1; m < 16; m++) begin
         for (int i = 0; i < 4; i++) begin
            cur[i] = rnd();
            wr(bank_t[i], cur[i]);
         end
         c = '0;
         c.bank_mask = 4'(m);
         op(c, '0);
         for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
               b = cur[i];
               cur[i] = alt[i];
               alt[i] = b;
            end
            rd(bank_t[i], cur[i]);
         end
      end
      $display("bank test done");
      finish_test();
   end
endmodule

// file: verification/dagu_mem_model.sv
// Purpose: data memory behind the address outputs
// Assumes: strobes land on the edge after they are shown
// Notes:   only 256 words; unwritten words read as a non-zero pattern
`timescale 1ns/100ps
module dagu_mem_model (
   // clock
   input  wire logic                clk,
   // address side
   input  wire dagu_pkg::dagu_addr_s addr_out,
   // word of the last read strobe
   output      logic [15:0]         rd_word
);
   logic [15:0] mem [256];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'hA5C3 ^ 16'(i);
   end
   always @(posedge clk) begin
      if (addr_out.mem_wr) mem[addr_out.x_addr[7:0]] <= addr_out.mem_wdata;
      if (addr_out.mem_rd) rd_word <= mem[addr_out.x_addr[7:0]];
   end
endmodule
